//--- cbclk_card.sv
// behavioural card model on the clock-run wire of one slot
`timescale 1ns/100ps
module cbclk_card (
	input  wire logic core_clk,
	input  wire logic arst_n,
	input  wire logic slot_clock,
	input  wire logic slot_reset_n,
	input  wire logic want_fast,
	input  wire logic run_wire,
	output logic      pull_low
);
	logic [1:0] rises;
	logic       clk_d;

	// pull low while the wire floats high, let go after two clock rises
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			pull_low <= 1'b0;
			rises    <= 2'h0;
			clk_d    <= 1'b0;
		end else begin
			clk_d <= slot_clock;
			if (!slot_reset_n) begin
				pull_low <= 1'b0;
				rises    <= 2'h0;
			end else if (pull_low) begin
				if (slot_clock && !clk_d)
					rises <= rises + 2'h1;
				if (rises == 2'h2)
					pull_low <= 1'b0;
			end else if (want_fast && run_wire) begin
				pull_low <= 1'b1;
				rises    <= 2'h0;
			end
		end
	end
endmodule : cbclk_card

//--- cbclk_gen.sv
// slot clock generator mirroring or dividing the synchronised host clock
`timescale 1ns/100ps
module cbclk_gen #(
	parameter int unsigned SLOW_DIV = cbclk_pkg::CBCLK_SLOW_DIV
) (
	input  wire logic                core_clk,
	input  wire logic                arst_n,
	input  wire logic                host_rise,
	input  wire logic                host_fall,
	input  wire cbclk_pkg::cbclk_mode_t mode,
	output logic                     slot_clock,
	output logic                     rise_pulse,
	output logic                     rise_next
);

	localparam int unsigned CW = (SLOW_DIV > 2) ? $clog2(SLOW_DIV) : 1;
	localparam logic [CW-1:0] DIV_LAST = CW'(SLOW_DIV - 1);
	localparam logic [CW-1:0] DIV_ZERO = '0;
	localparam logic [CW-1:0] DIV_ONE  = CW'(1);

	// a divider below two cannot give a slowed clock
	if (SLOW_DIV < 2) begin : g_bad_div
		$error("cbclk_gen: SLOW_DIV must be at least 2");
	end

	typedef struct packed {
		logic          clk_out;
		logic          rise;
		logic [CW-1:0] div_cnt;
	} cbclk_gen_state_t;

	cbclk_gen_state_t s_reg;
	cbclk_gen_state_t s_next;

	// high on a host rise when allowed, low on every host fall: a stop never cuts a high phase
	always_comb begin
		s_next = s_reg;
		s_next.rise = 1'b0;
		if (host_rise) begin
			if (mode == cbclk_pkg::CBCLK_MODE_RUN ||
			    (mode == cbclk_pkg::CBCLK_MODE_SLOW && s_reg.div_cnt == DIV_ZERO)) begin
				s_next.clk_out = 1'b1;
				s_next.rise = ~s_reg.clk_out;
			end
			if (mode == cbclk_pkg::CBCLK_MODE_SLOW) begin
				s_next.div_cnt = (s_reg.div_cnt == DIV_LAST) ? DIV_ZERO
				                                            : CW'(s_reg.div_cnt + DIV_ONE);
			end else begin
				s_next.div_cnt = DIV_ZERO;
			end
		end
		if (host_fall)
			s_next.clk_out = 1'b0;
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n)
			s_reg <= '0;
		else
			s_reg <= s_next;
	end

	assign slot_clock = s_reg.clk_out;
	assign rise_pulse = s_reg.rise;
	assign rise_next  = s_next.rise;

	a_run_follows_host: assert property (@(posedge core_clk) disable iff (!arst_n)
		host_rise && mode == cbclk_pkg::CBCLK_MODE_RUN |=> slot_clock)
		else $error("slot clock did not follow host clock rise");

	a_stop_holds_low: assert property (@(posedge core_clk) disable iff (!arst_n)
		mode == cbclk_pkg::CBCLK_MODE_STOP && !slot_clock |=> !slot_clock)
		else $error("stopped slot clock left the low state");

	a_sample_on_rise: assert property (@(posedge core_clk) disable iff (!arst_n)
		rise_pulse |-> slot_clock && !$past(slot_clock))
		else $error("sample pulse not on a slot clock rising edge");

endmodule : cbclk_gen

//--- cbclk_pkg.sv
// constants, states and carriers for the slot clock, clock-run and reset logic
// What this block does
// - Every slot signal except reset, clock-run, interrupt, status change, audio, card detect and voltage sense is sampled on the slot clock rising edge.
// - In normal running the slot clock has the same frequency as the host bus clock.
// - To save power the slot clock may be slowed or stopped, and when stopped it is held low.
// - The bridge tells the card of a coming clock slowdown through the clock-run line.
// - The slot clock-run handshake follows the host bus clock-run protocol and signalling.
// - While slot reset is asserted the bridge drives the card signals to valid levels.
// - Slot reset may be asserted at any time but is released only on a slot clock edge.
package cbclk_pkg;

	localparam int unsigned CBCLK_SLOTS      = 2;
	localparam int unsigned CBCLK_SLOW_DIV   = 4;   // host clock periods per slowed slot clock
	localparam int unsigned CBCLK_WATCH_EDGES = 4;  // slot clock edges the card has to object
	localparam logic [2:0]  CBCLK_CNT_ZERO   = 3'h0;
	localparam logic [2:0]  CBCLK_CNT_ONE    = 3'h1;

	// gray ordered: run, slow, stop
	typedef enum logic [1:0] {
		CBCLK_MODE_RUN  = 2'h0,
		CBCLK_MODE_SLOW = 2'h1,
		CBCLK_MODE_STOP = 2'h3
	} cbclk_mode_t;

	// clock-run sequencer, gray along run, deassert, watch, idle, restart
	typedef enum logic [2:0] {
		CBCLK_ST_RUN      = 3'h0,
		CBCLK_ST_DEASSERT = 3'h1,
		CBCLK_ST_WATCH    = 3'h3,
		CBCLK_ST_IDLE     = 3'h2,
		CBCLK_ST_RESTART  = 3'h6
	} cbclk_state_t;

	// requests from the bridge core for one slot
	typedef struct packed {
		logic power_save;   // ask to slow or stop the slot clock
		logic slow_not_stop; // 1 slows, 0 stops
		logic reset_req;    // slot reset wanted
	} cbclk_ctrl_t;

	// an open-drain style pin as output value and enable
	typedef struct packed {
		logic o;
		logic oe;
	} cbclk_pin_t;

endpackage : cbclk_pkg

//--- cbclk_slots.sv
// clock, clock-run and reset control for both slots of the bridge
`timescale 1ns/100ps
module cbclk_slots #(
	parameter int unsigned SLOTS       = cbclk_pkg::CBCLK_SLOTS,
	parameter int unsigned SLOW_DIV    = cbclk_pkg::CBCLK_SLOW_DIV,
	parameter int unsigned WATCH_EDGES = cbclk_pkg::CBCLK_WATCH_EDGES
) (
	input  wire logic                              core_clk,
	input  wire logic                              arst_n,
	input  wire logic                              host_pci_clk,
	input  wire cbclk_pkg::cbclk_ctrl_t [SLOTS-1:0] slot_ctrl,
	input  wire logic [SLOTS-1:0]                  slot_clock_run_in,
	output logic [SLOTS-1:0]                       slot_clock,
	output cbclk_pkg::cbclk_pin_t [SLOTS-1:0]      slot_clock_run,
	output logic [SLOTS-1:0]                       slot_reset_n,
	output logic [SLOTS-1:0]                       slot_park_en,
	output logic [SLOTS-1:0]                       slot_sample_en,
	output logic [SLOTS-1:0]                       slot_clock_reduced
);

	localparam logic [2:0] WATCH_LAST = 3'(WATCH_EDGES - 1);

	// the edge counter is three bits wide
	if (SLOTS < 1 || WATCH_EDGES < 1 || WATCH_EDGES > 8) begin : g_bad_param
		$error("cbclk_slots: SLOTS must be positive and WATCH_EDGES in 1..8");
	end

	// per-slot sequencer state
	typedef struct packed {
		cbclk_pkg::cbclk_state_t state;
		logic [2:0]             edge_cnt;
		logic                   slowed;
		logic                   run_o;
		logic                   run_oe;
		logic                   rst_n;
		logic                   park;
		logic                   cr_s1;
		logic                   cr_s2;
		logic                   reduced;
	} cbclk_slot_t;

	typedef struct packed {
		logic        host_s1;
		logic        host_s2;
		logic        host_s3;
		cbclk_slot_t [SLOTS-1:0] slot;
	} cbclk_top_t;

	cbclk_top_t s_reg;
	cbclk_top_t s_next;

	logic                   host_rise;
	logic                   host_fall;
	logic [SLOTS-1:0]       rise_next_w;
	logic [SLOTS-1:0]       rise_pulse_w;
	logic [SLOTS-1:0]       clock_w;
	cbclk_pkg::cbclk_mode_t mode_w [SLOTS];

	// host clock edges taken only from the second and third flop, never the first
	assign host_rise = s_reg.host_s2 & ~s_reg.host_s3;
	assign host_fall = ~s_reg.host_s2 & s_reg.host_s3;

	// clock mode follows the sequencer; a pending reset keeps the clock alive so it can release
	always_comb begin
		for (int i = 0; i < SLOTS; i++) begin
			if (s_reg.slot[i].state == cbclk_pkg::CBCLK_ST_IDLE && !s_reg.slot[i].park)
				mode_w[i] = s_reg.slot[i].slowed ? cbclk_pkg::CBCLK_MODE_SLOW
				                                 : cbclk_pkg::CBCLK_MODE_STOP;
			else
				mode_w[i] = cbclk_pkg::CBCLK_MODE_RUN;
		end
	end

	// one generator per slot, fully independent
	for (genvar g = 0; g < SLOTS; g++) begin : g_slot
		cbclk_gen #(
			.SLOW_DIV (SLOW_DIV)
		) u_gen (
			.core_clk   (core_clk),
			.arst_n     (arst_n),
			.host_rise  (host_rise),
			.host_fall  (host_fall),
			.mode       (mode_w[g]),
			.slot_clock (clock_w[g]),
			.rise_pulse (rise_pulse_w[g]),
			.rise_next  (rise_next_w[g])
		);
	end

	// clock-run handshake and slot reset sequencing
	always_comb begin
		s_next = s_reg;
		s_next.host_s1 = host_pci_clk;
		s_next.host_s2 = s_reg.host_s1;
		s_next.host_s3 = s_reg.host_s2;
		for (int i = 0; i < SLOTS; i++) begin
			s_next.slot[i].cr_s1 = slot_clock_run_in[i];
			s_next.slot[i].cr_s2 = s_reg.slot[i].cr_s1;
			unique case (s_reg.slot[i].state)
				cbclk_pkg::CBCLK_ST_RUN: begin
					if (slot_ctrl[i].power_save && !slot_ctrl[i].reset_req && rise_next_w[i]) begin
						s_next.slot[i].state = cbclk_pkg::CBCLK_ST_DEASSERT;
						s_next.slot[i].slowed = slot_ctrl[i].slow_not_stop;
					end
				end
				cbclk_pkg::CBCLK_ST_DEASSERT: begin
					if (rise_next_w[i]) begin
						s_next.slot[i].state = cbclk_pkg::CBCLK_ST_WATCH;
						s_next.slot[i].edge_cnt = cbclk_pkg::CBCLK_CNT_ZERO;
					end
				end
				cbclk_pkg::CBCLK_ST_WATCH: begin
					if (!s_reg.slot[i].cr_s2 || !slot_ctrl[i].power_save) begin
						s_next.slot[i].state = cbclk_pkg::CBCLK_ST_RUN;
					end else if (rise_next_w[i]) begin
						if (s_reg.slot[i].edge_cnt == WATCH_LAST)
							s_next.slot[i].state = cbclk_pkg::CBCLK_ST_IDLE;
						else
							s_next.slot[i].edge_cnt =
								3'(s_reg.slot[i].edge_cnt + cbclk_pkg::CBCLK_CNT_ONE);
					end
				end
				cbclk_pkg::CBCLK_ST_IDLE: begin
					// a card pull-down or our own wake-up restarts the clock
					if (!s_reg.slot[i].cr_s2 || !slot_ctrl[i].power_save || slot_ctrl[i].reset_req)
						s_next.slot[i].state = cbclk_pkg::CBCLK_ST_RESTART;
				end
				cbclk_pkg::CBCLK_ST_RESTART: begin
					if (rise_next_w[i])
						s_next.slot[i].state = cbclk_pkg::CBCLK_ST_RUN;
				end
				default: begin
					s_next.slot[i].state = cbclk_pkg::CBCLK_ST_RUN;
				end
			endcase
			// drive low while running, high for one clock to announce, released otherwise
			unique case (s_next.slot[i].state)
				cbclk_pkg::CBCLK_ST_RUN,
				cbclk_pkg::CBCLK_ST_RESTART: begin
					s_next.slot[i].run_o  = 1'b0;
					s_next.slot[i].run_oe = 1'b1;
				end
				cbclk_pkg::CBCLK_ST_DEASSERT: begin
					s_next.slot[i].run_o  = 1'b1;
					s_next.slot[i].run_oe = 1'b1;
				end
				default: begin
					s_next.slot[i].run_o  = 1'b1;
					s_next.slot[i].run_oe = 1'b0;
				end
			endcase
			// registered so the reduced flag leaves from a flop, not a decode
			s_next.slot[i].reduced = (s_next.slot[i].state == cbclk_pkg::CBCLK_ST_IDLE);
			// assert at once, release only together with a slot clock rise
			if (slot_ctrl[i].reset_req) begin
				s_next.slot[i].rst_n = 1'b0;
				s_next.slot[i].park  = 1'b1;
			end else if (!s_reg.slot[i].rst_n && rise_next_w[i]) begin
				s_next.slot[i].rst_n = 1'b1;
				s_next.slot[i].park  = 1'b0;
			end
		end
	end

	// reset leaves the slot in reset, parked, with the clock running
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			s_reg <= '0;
			for (int i = 0; i < SLOTS; i++) begin
				s_reg.slot[i].state  <= cbclk_pkg::CBCLK_ST_RUN;
				s_reg.slot[i].run_oe <= 1'b1;
				s_reg.slot[i].park   <= 1'b1;
				s_reg.slot[i].cr_s1  <= 1'b1;
				s_reg.slot[i].cr_s2  <= 1'b1;
			end
		end else begin
			s_reg <= s_next;
		end
	end

	// outputs straight from the registers
	always_comb begin
		for (int i = 0; i < SLOTS; i++) begin
			slot_clock_run[i].o   = s_reg.slot[i].run_o;
			slot_clock_run[i].oe  = s_reg.slot[i].run_oe;
			slot_reset_n[i]       = s_reg.slot[i].rst_n;
			slot_park_en[i]       = s_reg.slot[i].park;
			slot_clock_reduced[i] = s_reg.slot[i].reduced;
		end
	end
	assign slot_clock     = clock_w;
	assign slot_sample_en = rise_pulse_w;

	for (genvar g = 0; g < SLOTS; g++) begin : g_chk
		a_deassert_drive: assert property (@(posedge core_clk) disable iff (!arst_n)
			s_reg.slot[g].state == cbclk_pkg::CBCLK_ST_DEASSERT
			|-> s_reg.slot[g].run_oe && s_reg.slot[g].run_o)
			else $error("clock-run not driven high while announcing slowdown");

		a_run_drive_low: assert property (@(posedge core_clk) disable iff (!arst_n)
			s_reg.slot[g].state == cbclk_pkg::CBCLK_ST_RUN
			|-> s_reg.slot[g].run_oe && !s_reg.slot[g].run_o)
			else $error("clock-run not driven low while clock runs");

		a_card_restart: assert property (@(posedge core_clk) disable iff (!arst_n)
			s_reg.slot[g].state == cbclk_pkg::CBCLK_ST_IDLE && !s_reg.slot[g].cr_s2
			|=> s_reg.slot[g].state == cbclk_pkg::CBCLK_ST_RESTART)
			else $error("card clock request ignored");

		a_reset_parks: assert property (@(posedge core_clk) disable iff (!arst_n)
			!slot_reset_n[g] |-> slot_park_en[g])
			else $error("slot in reset while signals not parked");

		a_reset_release: assert property (@(posedge core_clk) disable iff (!arst_n)
			$rose(slot_reset_n[g]) |-> $rose(slot_clock[g]))
			else $error("slot reset released off a slot clock edge");

		a_reset_assert: assert property (@(posedge core_clk) disable iff (!arst_n)
			slot_ctrl[g].reset_req |=> !slot_reset_n[g])
			else $error("slot reset not asserted at once");
	end

endmodule : cbclk_slots

//--- tb.sv
// self-checking bench for the two-slot clock, clock-run and reset block
`timescale 1ns/100ps
module tb;
	localparam int SDIV = 4;
	logic                        core_clk = 1'b0;
	logic                        arst_n = 1'b0;
	logic                        host_pci_clk = 1'b0;
	cbclk_pkg::cbclk_ctrl_t [1:0] slot_ctrl = '0;
	cbclk_pkg::cbclk_pin_t [1:0]  slot_clock_run;
	logic [1:0]                  want = 2'h0;
	logic [1:0]                  card_pull, run_wire, prev_clk;
	logic [1:0]                  slot_clock, slot_reset_n, slot_park_en;
	logic [1:0]                  slot_sample_en, slot_clock_reduced;
	int                          error_cnt = 0, n_tests = 0, cyc = 0;

	always #50 core_clk = ~core_clk;
	always #400 host_pci_clk = ~host_pci_clk;

	cbclk_slots #(.SLOTS(2), .SLOW_DIV(SDIV), .WATCH_EDGES(4)) u_cbclk_slots (
		.core_clk(core_clk), .arst_n(arst_n), .host_pci_clk(host_pci_clk),
		.slot_ctrl(slot_ctrl), .slot_clock_run_in(run_wire), .slot_clock(slot_clock),
		.slot_clock_run(slot_clock_run), .slot_reset_n(slot_reset_n),
		.slot_park_en(slot_park_en), .slot_sample_en(slot_sample_en),
		.slot_clock_reduced(slot_clock_reduced));

	// wire level: pulled up, low when either party drives low
	for (genvar g = 0; g < 2; g++) begin : g_slot
		assign run_wire[g] = ~(card_pull[g] | (slot_clock_run[g].oe & ~slot_clock_run[g].o));
		cbclk_card u_cbclk_card (
			.core_clk(core_clk), .arst_n(arst_n), .slot_clock(slot_clock[g]),
			.slot_reset_n(slot_reset_n[g]), .want_fast(want[g]), .run_wire(run_wire[g]),
			.pull_low(card_pull[g]));
	end

	task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %0h seen %0h", name, exp, seen);
		end
	endtask : check

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : tally_and_finish

	task automatic step(int n = 1);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : step

	task automatic rise(int s);
		for (int k = 0; k < 200 && slot_clock[s] !== 1'b0; k++) step();
		for (int k = 0; k < 200 && slot_clock[s] !== 1'b1; k++) step();
	endtask : rise

	// expected period in core cycles: host period is eight of them
	function automatic logic [15:0] exp_period(bit slow);
		return slow ? 16'(8 * SDIV) : 16'h0008;
	endfunction : exp_period

	task automatic period(int s, bit slow);
		int t;
		rise(s);
		t = cyc;
		rise(s);
		check("slot_clock period", 16'(cyc - t), exp_period(slow));
	endtask : period

	// sample strobe must mark the first high cycle of the slot clock
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		prev_clk <= slot_clock;
		if (arst_n === 1'b1)
			check("slot_sample_en", 16'(slot_sample_en), 16'(slot_clock & ~prev_clk));
	end

	initial begin
		#5_000_000;
		error_cnt++;
		tally_and_finish();
	end

	initial begin
		int s, hi, wake;
		bit slow, obj;
		void'($urandom(32'hab0f));
		step(5);
		check("reset_n in reset", 16'(slot_reset_n), 16'h0000);
		check("park_en in reset", 16'(slot_park_en), 16'h0003);
		check("clock in reset", 16'(slot_clock), 16'h0000);
		step(5);
		arst_n = 1'b1;
		step(40);
		for (int it = 0; it < 12; it++) begin
			s = $urandom % 2;
			slow = (it < 2) ? it[0] : $urandom % 2;
			obj = (it == 2) ? 1'b1 : (it < 4) ? 1'b0 : ($urandom % 4 == 0);
			period(s, 1'b0);
			rise(s);
			slot_ctrl[s].power_save = 1'b1;
			slot_ctrl[s].slow_not_stop = slow;
			want[s] = obj;
			for (int k = 0; k < 40 && slot_clock_run[s].o !== 1'b1; k++) step();
			check("announce o", 16'(slot_clock_run[s].o), 16'h0001);
			check("announce oe", 16'(slot_clock_run[s].oe), 16'h0001);
			if (obj) begin
				step(60);
				check("objected reduced", 16'(slot_clock_reduced[s]), 16'h0000);
			end else begin
				for (int k = 0; k < 300 && slot_clock_reduced[s] !== 1'b1; k++) step();
				check("reduced", 16'(slot_clock_reduced[s]), 16'h0001);
				check("released oe", 16'(slot_clock_run[s].oe), 16'h0000);
				check("other slot", 16'(slot_clock_reduced[1-s]), 16'h0000);
				period(1 - s, 1'b0);
				if (slow) begin
					period(s, 1'b1);
				end else begin
					hi = 0;
					repeat (100) begin
						step();
						hi += slot_clock[s];
					end
					check("stopped high cycles", 16'(hi), 16'h0000);
				end
				// card request, own wake-up, or a slot reset that must restart the clock
				wake = (it == 3) ? 2 : (it < 2) ? it : $urandom % 3;
				case (wake)
					0: want[s] = 1'b1;
					1: slot_ctrl[s].power_save = 1'b0;
					default: slot_ctrl[s].reset_req = 1'b1;
				endcase
				for (int k = 0; k < 100 && slot_clock_reduced[s] !== 1'b0; k++) step();
				check("woken", 16'(slot_clock_reduced[s]), 16'h0000);
				rise(s);
				period(s, 1'b0);
			end
			slot_ctrl[s].power_save = 1'b0;
			want[s] = 1'b0;
			step(60);
			check("running o", 16'(slot_clock_run[s].o), 16'h0000);
			check("running oe", 16'(slot_clock_run[s].oe), 16'h0001);
			slot_ctrl[s].reset_req = 1'b1;
			step(2);
			check("reset_n asserted", 16'(slot_reset_n[s]), 16'h0000);
			check("park_en asserted", 16'(slot_park_en[s]), 16'h0001);
			check("card released", 16'(card_pull[s]), 16'h0000);
			step($urandom % 20);
			slot_ctrl[s].reset_req = 1'b0;
			for (int k = 0; k < 40 && slot_reset_n[s] !== 1'b1; k++) step();
			check("reset_n released", 16'(slot_reset_n[s]), 16'h0001);
			check("release with rise", 16'(slot_clock[s] & ~prev_clk[s]), 16'h0001);
			check("park_en released", 16'(slot_park_en[s]), 16'h0000);
			step(20);
		end
		tally_and_finish();
	end
endmodule : tb
